// *** design/smcd_defs.vh ***
// constants for the serial mram command decoder
`ifndef SMCD_DEFS_VH
`define SMCD_DEFS_VH

// ----------------------------------------------------------------------
// apb register offsets and fields
// ----------------------------------------------------------------------
`define SMCD_OFF_CFG        8'h00
`define SMCD_OFF_STAT       8'h04
`define SMCD_OFF_ADDR       8'h08
`define SMCD_CFG_LAT_LSB    0
`define SMCD_CFG_LAT_MSB    3
`define SMCD_CFG_WG_LSB     4
`define SMCD_CFG_WG_MSB     5
`define SMCD_LAT_RST        4'h8
`define SMCD_WG_RST         2'h0
`define SMCD_WG_NEED_WEL    2'h0

// ----------------------------------------------------------------------
// interface modes and lane counts
// ----------------------------------------------------------------------
`define SMCD_MODE_SINGLE    2'h0
`define SMCD_MODE_DUAL      2'h1
`define SMCD_MODE_QUAD      2'h2
`define SMCD_W1             3'h1
`define SMCD_W2             3'h2
`define SMCD_W4             3'h4

// ----------------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------------
`define SMCD_CMD_BITS       5'h08
`define SMCD_ADDR_BITS      5'h18
`define SMCD_BYTE_BITS      4'h8

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define SMCD_OP_READ        8'h03
`define SMCD_OP_FRD_SR      8'h0b
`define SMCD_OP_FRD_DR      8'h0d
`define SMCD_OP_O2RD_SR     8'h3b
`define SMCD_OP_O2RD_DR     8'h3d
`define SMCD_OP_O4RD_SR     8'h6b
`define SMCD_OP_O4RD_DR     8'h6d
`define SMCD_OP_IO2RD_SR    8'hbb
`define SMCD_OP_IO2RD_DR    8'hbd
`define SMCD_OP_IO4RD_SR    8'heb
`define SMCD_OP_IO4RD_DR    8'hed
`define SMCD_OP_WRITE       8'h02
`define SMCD_OP_FWR_SR      8'hda
`define SMCD_OP_FWR_DR      8'hde
`define SMCD_OP_I2WR_SR     8'ha2
`define SMCD_OP_I2WR_DR     8'ha4
`define SMCD_OP_I4WR_SR     8'h32
`define SMCD_OP_I4WR_DR     8'h31
`define SMCD_OP_IO2WR_SR    8'ha1
`define SMCD_OP_IO2WR_DR    8'ha3
`define SMCD_OP_IO4WR_SR    8'hd2
`define SMCD_OP_IO4WR_DR    8'hd1
`define SMCD_OP_XRD         8'h4b
`define SMCD_OP_XWR         8'h42
`define SMCD_OP_WEL_SET     8'h06
`define SMCD_OP_WEL_CLR     8'h04
`define SMCD_OP_DUAL        8'h37
`define SMCD_OP_QUAD        8'h38
`define SMCD_OP_SINGLE      8'hff
`define SMCD_OP_RST_EN      8'h66
`define SMCD_OP_RST         8'h99

`endif

// *** design/smcd_sync.v ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module smcd_sync #(
    parameter       W   = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         resetn,
    // pins in, synchronised out
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_q;

    // first stage feeds only the second
    always @(posedge ref_clk) begin
        if (!resetn) begin
            meta_q   <= RST;
            sync_out <= RST;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // smcd_sync

`default_nettype wire

// *** design/smcd_opdec.v ***
// opcode table: lane widths, data rate, latency and kind
`timescale 1ns/1ps
`include "smcd_defs.vh"
`default_nettype none

module smcd_opdec (
    // opcode and current interface mode
    input  wire [7:0] cmd,
    input  wire [1:0] mode,
    // decoded attributes
    output reg        ok,
    output reg        ctrl,
    output reg        rd,
    output reg        ddr,
    output reg        lat,
    output reg        aug,
    output reg  [2:0] aw,
    output reg  [2:0] dw
);

    reg [2:0] mw;
    reg       sgl;

    always @* begin
        mw   = (mode == `SMCD_MODE_QUAD) ? `SMCD_W4 :
               (mode == `SMCD_MODE_DUAL) ? `SMCD_W2 : `SMCD_W1;
        sgl  = (mode == `SMCD_MODE_SINGLE);
        ok   = 1'b1;
        ctrl = 1'b0;
        rd   = 1'b0;
        ddr  = 1'b0;
        lat  = 1'b0;
        aug  = 1'b0;
        aw   = `SMCD_W1;
        dw   = `SMCD_W1;
        case (cmd)
            `SMCD_OP_READ: begin
                ok = sgl; rd = 1'b1;
            end
            `SMCD_OP_FRD_SR: begin
                rd = 1'b1; lat = 1'b1; aw = mw; dw = mw;
            end
            `SMCD_OP_FRD_DR: begin
                rd = 1'b1; lat = 1'b1; ddr = 1'b1; aw = mw; dw = mw;
            end
            `SMCD_OP_O2RD_SR, `SMCD_OP_O2RD_DR: begin
                ok = sgl; rd = 1'b1; lat = 1'b1; dw = `SMCD_W2;
                ddr = (cmd == `SMCD_OP_O2RD_DR);
            end
            `SMCD_OP_O4RD_SR, `SMCD_OP_O4RD_DR: begin
                ok = sgl; rd = 1'b1; lat = 1'b1; dw = `SMCD_W4;
                ddr = (cmd == `SMCD_OP_O4RD_DR);
            end
            `SMCD_OP_IO2RD_SR, `SMCD_OP_IO2RD_DR: begin
                ok = sgl; rd = 1'b1; lat = 1'b1; aw = `SMCD_W2; dw = `SMCD_W2;
                ddr = (cmd == `SMCD_OP_IO2RD_DR);
            end
            `SMCD_OP_IO4RD_SR, `SMCD_OP_IO4RD_DR: begin
                ok = sgl; rd = 1'b1; lat = 1'b1; aw = `SMCD_W4; dw = `SMCD_W4;
                ddr = (cmd == `SMCD_OP_IO4RD_DR);
            end
            `SMCD_OP_WRITE:    ok = sgl;
            `SMCD_OP_FWR_SR, `SMCD_OP_FWR_DR: begin
                aw = mw; dw = mw; ddr = (cmd == `SMCD_OP_FWR_DR);
            end
            `SMCD_OP_I2WR_SR, `SMCD_OP_I2WR_DR: begin
                ok = sgl; dw = `SMCD_W2; ddr = (cmd == `SMCD_OP_I2WR_DR);
            end
            `SMCD_OP_I4WR_SR, `SMCD_OP_I4WR_DR: begin
                ok = sgl; dw = `SMCD_W4; ddr = (cmd == `SMCD_OP_I4WR_DR);
            end
            `SMCD_OP_IO2WR_SR, `SMCD_OP_IO2WR_DR: begin
                ok = sgl; aw = `SMCD_W2; dw = `SMCD_W2;
                ddr = (cmd == `SMCD_OP_IO2WR_DR);
            end
            `SMCD_OP_IO4WR_SR, `SMCD_OP_IO4WR_DR: begin
                ok = sgl; aw = `SMCD_W4; dw = `SMCD_W4;
                ddr = (cmd == `SMCD_OP_IO4WR_DR);
            end
            `SMCD_OP_XRD: begin
                ok = sgl; rd = 1'b1; lat = 1'b1; aug = 1'b1;
            end
            `SMCD_OP_XWR: begin
                ok = sgl; aug = 1'b1;
            end
            `SMCD_OP_WEL_SET, `SMCD_OP_WEL_CLR, `SMCD_OP_DUAL, `SMCD_OP_QUAD,
            `SMCD_OP_SINGLE, `SMCD_OP_RST_EN, `SMCD_OP_RST:
                ctrl = 1'b1;
            default:           ok = 1'b0;
        endcase
    end

endmodule // smcd_opdec

`default_nettype wire

// *** design/smcd_top.v ***
// serial mram array command decoder and sequencer with apb config
//
// Function
// - opcode 03: plain single-line read, no latency
// - opcode 0B: fast single-rate read, mode lanes
// - opcode 0D: fast double-rate read, mode lanes
// - 3B/3D: read, data on two lines
// - 6B/6D: read, data on four lines
// - BB/BD: address and data on two lines
// - EB/ED: address and data on four lines
// - latency cycles sit between address and data
// - latency count taken from four-bit config field
// - opcode 02: plain single-line write, no latency
// - DA/DE: fast writes single and double rate
// - A2/A4: write, data on two lines
// - 32/31: write, data on four lines
// - A1/A3: address and data on two lines
// - D2/D1: address and data on four lines
// - 4B/42 read/write the 256-byte area
// - two-bit field decides write-enable prerequisite
// - single-line mode after reset and soft reset
// - write-enable latch volatile, set by command
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "smcd_defs.vh"
`default_nettype none

module smcd_top (
    // clock and reset
    input  wire        ref_clk,
    input  wire        resetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // serial link pins
    input  wire        cs_n,
    input  wire        sclk,
    input  wire [3:0]  io_in,
    output reg  [3:0]  io_out,
    output reg  [3:0]  io_oe,
    // memory array port
    output reg  [23:0] mem_addr,
    output reg  [7:0]  mem_wdata,
    output reg         mem_we,
    output reg         mem_re,
    output reg         mem_aug,
    input  wire [7:0]  mem_rdata
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_CMD  = 6'b000010;
    localparam [5:0] S_ADDR = 6'b000100;
    localparam [5:0] S_LAT  = 6'b001000;
    localparam [5:0] S_RD   = 6'b010000;
    localparam [5:0] S_WR   = 6'b100000;
    localparam [5:0] S_IGN  = 6'b000000;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    wire [5:0]  pins_s;
    wire        cs_s;
    wire        sclk_s;
    wire [3:0]  io_s;
    reg         sclk_d_q;
    reg  [5:0]  st_q;
    reg  [31:0] sr_q;
    reg  [4:0]  cnt_q;
    reg  [3:0]  lat_cnt_q;
    reg  [3:0]  bcnt_q;
    reg  [7:0]  osr_q;
    reg  [7:0]  nxt_q;
    reg         rvalid_q;
    reg  [23:0] addr_q;
    reg         rd_q;
    reg         ddr_q;
    reg         lat_q;
    reg         aug_q;
    reg         wr_ok_q;
    reg  [2:0]  aw_q;
    reg  [2:0]  dw_q;
    reg  [1:0]  mode_q;
    reg         write_enable_latch_q;
    reg         arm_q;
    reg  [3:0]  latency_config_reg_q;
    reg  [1:0]  write_gate_config_reg_q;
    wire        rise;
    wire        fall;
    wire        cap;
    wire        drv;
    reg  [2:0]  w;
    wire [2:0]  mw;
    wire [31:0] sh;
    wire [4:0]  cnt_nx;
    wire [7:0]  obyte;
    wire        dec_ok;
    wire        dec_ctrl;
    wire        dec_rd;
    wire        dec_ddr;
    wire        dec_lat;
    wire        dec_aug;
    wire [2:0]  dec_aw;
    wire [2:0]  dec_dw;
    reg  [31:0] rd_mux;
    reg         bad_addr;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function [31:0] shin;
        input [31:0] s;
        input [2:0]  wd;
        input [3:0]  io;
        begin
            case (wd)
                `SMCD_W4: shin = {s[27:0], io};
                `SMCD_W2: shin = {s[29:0], io[1:0]};
                default:  shin = {s[30:0], io[0]};
            endcase
        end
    endfunction

    function [3:0] lanes;
        input [2:0] wd;
        input [7:0] b;
        input       en;
        begin
            case (wd)
                `SMCD_W4: lanes = en ? 4'hf : b[7:4];
                `SMCD_W2: lanes = en ? 4'h3 : {2'b00, b[7:6]};
                default:  lanes = en ? 4'h2 : {2'b00, b[7], 1'b0};
            endcase
        end
    endfunction

    // the augmented area wraps inside its 256 bytes
    function [23:0] inc;
        input [23:0] a;
        input        x;
        begin
            inc = x ? {16'h0000, a[7:0] + 8'h01} : a + 24'h000001;
        end
    endfunction

    // ------------------------------------------------------------------
    // pin capture and edge finding
    // ------------------------------------------------------------------
    smcd_sync #(.W(6), .RST(6'b100000)) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({cs_n, sclk, io_in}),
        .sync_out (pins_s)
    );

    assign cs_s   = pins_s[5];
    assign sclk_s = pins_s[4];
    assign io_s   = pins_s[3:0];
    assign rise   = sclk_s & ~sclk_d_q;
    assign fall   = ~sclk_s & sclk_d_q;
    // opcode is always single rate; address and data follow the opcode's rate
    assign cap    = (st_q == S_CMD) ? rise : (rise | (ddr_q & fall));
    assign drv    = fall | (ddr_q & rise);
    assign mw     = (mode_q == `SMCD_MODE_QUAD) ? `SMCD_W4 :
                    (mode_q == `SMCD_MODE_DUAL) ? `SMCD_W2 : `SMCD_W1;

    always @* begin
        case (st_q)
            S_CMD:   w = mw;
            S_ADDR:  w = aw_q;
            default: w = dw_q;
        endcase
    end

    assign sh     = shin(sr_q, w, io_s);
    assign cnt_nx = cnt_q + {2'b00, w};
    assign obyte  = (bcnt_q == 4'h0) ? nxt_q : osr_q;

    smcd_opdec u_dec (
        .cmd  (sh[7:0]),
        .mode (mode_q),
        .ok   (dec_ok),
        .ctrl (dec_ctrl),
        .rd   (dec_rd),
        .ddr  (dec_ddr),
        .lat  (dec_lat),
        .aug  (dec_aug),
        .aw   (dec_aw),
        .dw   (dec_dw)
    );

    // ------------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            sclk_d_q             <= 1'b0;
            st_q                 <= S_IDLE;
            sr_q                 <= 32'h00000000;
            cnt_q                <= 5'h00;
            lat_cnt_q            <= 4'h0;
            bcnt_q               <= 4'h0;
            osr_q                <= 8'h00;
            nxt_q                <= 8'h00;
            rvalid_q             <= 1'b0;
            addr_q               <= 24'h000000;
            rd_q                 <= 1'b0;
            ddr_q                <= 1'b0;
            lat_q                <= 1'b0;
            aug_q                <= 1'b0;
            wr_ok_q              <= 1'b0;
            aw_q                 <= `SMCD_W1;
            dw_q                 <= `SMCD_W1;
            mode_q               <= `SMCD_MODE_SINGLE;
            write_enable_latch_q <= 1'b0;
            arm_q                <= 1'b0;
            io_out               <= 4'h0;
            io_oe                <= 4'h0;
            mem_addr             <= 24'h000000;
            mem_wdata            <= 8'h00;
            mem_we               <= 1'b0;
            mem_re               <= 1'b0;
            mem_aug              <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
            mem_we   <= 1'b0;
            mem_re   <= 1'b0;
            rvalid_q <= mem_re;
            if (rvalid_q) begin
                nxt_q <= mem_rdata;
            end
            if (cs_s) begin
                // deselect ends any frame and releases the pins
                st_q  <= S_IDLE;
                io_oe <= 4'h0;
            end else begin
                case (st_q)
                    S_IDLE: begin
                        st_q  <= S_CMD;
                        cnt_q <= 5'h00;
                        sr_q  <= 32'h00000000;
                    end
                    S_CMD: if (cap) begin
                        sr_q  <= sh;
                        cnt_q <= cnt_nx;
                        if (cnt_nx == `SMCD_CMD_BITS) begin
                            cnt_q <= 5'h00;
                            arm_q <= (sh[7:0] == `SMCD_OP_RST_EN);
                            rd_q  <= dec_rd;
                            ddr_q <= dec_ddr;
                            lat_q <= dec_lat;
                            aug_q <= dec_aug;
                            aw_q  <= dec_aw;
                            dw_q  <= dec_dw;
                            wr_ok_q <= write_enable_latch_q |
                                (write_gate_config_reg_q != `SMCD_WG_NEED_WEL);
                            if (!dec_ok || dec_ctrl) begin
                                st_q <= S_IGN;
                            end else begin
                                st_q <= S_ADDR;
                            end
                            case (sh[7:0])
                                `SMCD_OP_WEL_SET: write_enable_latch_q <= 1'b1;
                                `SMCD_OP_WEL_CLR: write_enable_latch_q <= 1'b0;
                                `SMCD_OP_DUAL:    mode_q <= `SMCD_MODE_DUAL;
                                `SMCD_OP_QUAD:    mode_q <= `SMCD_MODE_QUAD;
                                `SMCD_OP_SINGLE:  mode_q <= `SMCD_MODE_SINGLE;
                                `SMCD_OP_RST: if (arm_q) begin
                                    mode_q               <= `SMCD_MODE_SINGLE;
                                    write_enable_latch_q <= 1'b0;
                                end
                                default: ;
                            endcase
                        end
                    end
                    S_ADDR: if (cap) begin
                        sr_q  <= sh;
                        cnt_q <= cnt_nx;
                        if (cnt_nx == `SMCD_ADDR_BITS) begin
                            cnt_q     <= 5'h00;
                            lat_cnt_q <= 4'h0;
                            bcnt_q    <= 4'h0;
                            // the area only decodes the low byte
                            addr_q    <= aug_q ? {16'h0000, sh[7:0]} : sh[23:0];
                            if (!rd_q) begin
                                st_q <= S_WR;
                            end else if (lat_q && latency_config_reg_q != 4'h0) begin
                                st_q <= S_LAT;
                            end else begin
                                st_q     <= S_RD;
                                mem_re   <= 1'b1;
                                mem_aug  <= aug_q;
                                mem_addr <= aug_q ? {16'h0000, sh[7:0]} : sh[23:0];
                                addr_q   <= inc(aug_q ? {16'h0000, sh[7:0]} : sh[23:0],
                                                aug_q);
                            end
                        end
                    end
                    S_LAT: if (rise) begin
                        lat_cnt_q <= lat_cnt_q + 4'h1;
                        if (lat_cnt_q + 4'h1 == latency_config_reg_q) begin
                            st_q     <= S_RD;
                            mem_re   <= 1'b1;
                            mem_aug  <= aug_q;
                            mem_addr <= addr_q;
                            addr_q   <= inc(addr_q, aug_q);
                        end
                    end
                    S_RD: if (drv) begin
                        io_oe  <= lanes(dw_q, 8'h00, 1'b1);
                        io_out <= lanes(dw_q, obyte, 1'b0);
                        osr_q  <= obyte << dw_q;
                        bcnt_q <= ((bcnt_q == 4'h0) ? `SMCD_BYTE_BITS : bcnt_q)
                                  - {1'b0, dw_q};
                        if (bcnt_q == 4'h0) begin
                            // prefetch keeps one byte ahead of the pins
                            mem_re   <= 1'b1;
                            mem_aug  <= aug_q;
                            mem_addr <= addr_q;
                            addr_q   <= inc(addr_q, aug_q);
                        end
                    end
                    S_WR: if (cap) begin
                        sr_q  <= sh;
                        cnt_q <= cnt_nx;
                        if (cnt_nx == {1'b0, `SMCD_BYTE_BITS}) begin
                            cnt_q     <= 5'h00;
                            mem_we    <= wr_ok_q;
                            mem_aug   <= aug_q;
                            mem_addr  <= addr_q;
                            mem_wdata <= sh[7:0];
                            addr_q    <= inc(addr_q, aug_q);
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    always @* begin
        bad_addr = 1'b0;
        rd_mux   = 32'h00000000;
        case (paddr)
            `SMCD_OFF_CFG:  rd_mux = {26'h0, write_gate_config_reg_q, latency_config_reg_q};
            `SMCD_OFF_STAT: rd_mux = {28'h0, ~cs_s, mode_q, write_enable_latch_q};
            `SMCD_OFF_ADDR: rd_mux = {8'h00, addr_q};
            default:        bad_addr = 1'b1;
        endcase
    end

    // one wait state; a write lands on the edge that sees pready high
    always @(posedge ref_clk) begin
        if (!resetn) begin
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
            prdata                  <= 32'h00000000;
            latency_config_reg_q    <= `SMCD_LAT_RST;
            write_gate_config_reg_q <= `SMCD_WG_RST;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & bad_addr;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
            if (psel && penable && pready && pwrite && paddr == `SMCD_OFF_CFG) begin
                latency_config_reg_q    <= pwdata[`SMCD_CFG_LAT_MSB:`SMCD_CFG_LAT_LSB];
                write_gate_config_reg_q <= pwdata[`SMCD_CFG_WG_MSB:`SMCD_CFG_WG_LSB];
            end
        end
    end

endmodule // smcd_top

`default_nettype wire

// *** dv/smcd_chk.sv ***
// port checker for the serial mram command decoder
`timescale 1ns/1ps
`default_nettype none
module smcd_chk (
    // clock, reset, apb
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // link and memory
    input wire logic        cs_n,
    input wire logic [3:0]  io_oe,
    input wire logic [23:0] mem_addr,
    input wire logic        mem_we,
    input wire logic        mem_aug
);
    // ------------------------------
    // properties
    // ------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence apb_take; psel && penable && !pready; endsequence
    // five cycles covers the two-flop sync plus the output register
    sequence cs_idle; cs_n [*5]; endsequence
    apb_wait_a: assert property (apb_take |=> pready)
        else $error("pready missing after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    we_pulse_a: assert property (mem_we |=> !mem_we)
        else $error("write strobe longer than one cycle");
    oe_release_a: assert property (cs_idle |-> io_oe == 4'h0)
        else $error("pins driven while deselected");
    idle_write_a: assert property (cs_idle |-> !mem_we)
        else $error("write strobe while deselected");
    oe_lanes_a: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("illegal lane enable pattern");
    aug_page_a: assert property (mem_aug && mem_we |-> mem_addr[23:8] == 16'h0)
        else $error("area access outside low page");
endmodule // smcd_chk
bind smcd_top smcd_chk smcd_chk_i (.ref_clk, .resetn, .psel, .penable, .pready,
    .pslverr, .cs_n, .io_oe, .mem_addr, .mem_we, .mem_aug);
`default_nettype wire

// *** dv/smcd_host.sv ***
// host serial controller model driving the link pins
`timescale 1ns/1ps
`default_nettype none
module smcd_host (
    // clock
    input  wire logic       ref_clk,
    // link pins
    output var  logic       cs_n,
    output var  logic       sclk,
    output var  logic [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_in = 4'h0;
    end
    // ------------------------------
    // link tasks
    // ------------------------------
    task automatic sel(input logic v);
        // long enough deselect for the checker to see the pins released
        repeat (8) @(posedge ref_clk);
        cs_n <= v;
    endtask
    // 5 mhz link, below the slowest limit idle lines carry the inverse
    task automatic shift(input int n, input logic [7:0] b, output logic [7:0] r);
        for (int i = 0; i < n; i++) begin
            io_in <= {{3{~b[7-i]}}, b[7-i]};
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            // an undriven line reads as the inverse of the last value
            r = {r[6:0], io_oe[1] ? io_out[1] : ~io_out[1]};
            sclk <= 1'b0;
        end
    endtask
endmodule // smcd_host
`default_nettype wire

// *** dv/smcd_tb_top.sv ***
// self-checking bench for the serial mram command decoder
`timescale 1ns/1ps
`default_nettype none
module spi_mram_array_command_decoder_tb_top;
    logic ref_clk = 1'b0, resetn = 1'b0, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed = 32'h8358e743;
    wire cs_n, sclk, mem_we, mem_re, mem_aug;
    wire [3:0] io_in, io_out, io_oe;
    wire [23:0] mem_addr;
    wire [7:0] mem_wdata, mem_rdata;
    logic [23:0] a;
    logic [32:0] wq[$];
    int err_count, n_checks, cyc;
    smcd_top smcd_top_i (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cs_n, .sclk, .io_in, .io_out, .io_oe, .mem_addr,
        .mem_wdata, .mem_we, .mem_re, .mem_aug, .mem_rdata);
    smcd_host smcd_host_i (.ref_clk, .cs_n, .sclk, .io_in, .io_out, .io_oe);
    assign mem_rdata = mem_addr[7:0] ^ 8'h5a;
    initial forever #12.5 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input string nm, input logic [39:0] ex, input logic [39:0] got);
        n_checks++;
        if (got !== ex) begin
            $display("MISMATCH %s exp %h got %h", nm, ex, got);
            err_count++;
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // k: 0 nothing expected, 1 write expected, 2 read checked
    task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int lat, n, k);
        logic [7:0] r, d;
        smcd_host_i.sel(1'b0);
        smcd_host_i.shift(8, op, r);
        for (int i = 0; i < 3; i++) smcd_host_i.shift(8, ad[23-8*i -: 8], r);
        if (lat > 0) smcd_host_i.shift(lat, 8'h00, r);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            // queued before the byte goes out, so the strobe never finds it missing
            if (k == 1) wq.push_back({op == 8'h42, ad + 24'(i), d});
            smcd_host_i.shift(8, d, r);
            if (k == 2) chk("read byte", (ad[7:0] + 8'(i)) ^ 8'h5a, r);
        end
        smcd_host_i.sel(1'b1);
        chk("pending writes", 0, wq.size());
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            test_done;
        end else if (resetn && mem_we) chk("write", wq.size() ? wq.pop_front() : 0,
            {mem_aug, mem_addr, mem_wdata});
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        apb(1'b0, 8'h00, 0);
        chk("cfg", 8, rd);
        apb(1'b0, 8'h04, 0);
        chk("stat", 0, rd);
        apb(1'b0, 8'h0c, 0);
        chk("slverr", 1, e);
        seed = lfsr(seed);
        a = {seed[23:8], 8'h10};
        frame(8'h02, a, 0, 2, 0);
        frame(8'h06, 0, 0, 0, 0);
        apb(1'b0, 8'h04, 0);
        chk("wel", 1, rd[0]);
        frame(8'h02, a, 0, 3, 1);
        apb(1'b0, 8'h08, 0);
        chk("next addr", a + 24'd3, rd);
        frame(8'h42, 24'h0000fe, 0, 2, 1);
        apb(1'b1, 8'h00, 32'h12);
        frame(8'h03, a, 0, 2, 2);
        frame(8'h0b, a, 2, 2, 2);
        frame(8'h4b, 24'h000020, 2, 2, 2);
        frame(8'h37, 0, 0, 0, 0);
        apb(1'b0, 8'h04, 0);
        chk("stat dual", 3, rd);
        // two-lane opcodes: io1 carries the inverse, so a0 sends 66 and 50 sends 99
        frame(8'ha0, 0, 0, 0, 0);
        frame(8'h50, 0, 0, 0, 0);
        apb(1'b0, 8'h04, 0);
        chk("stat after soft reset", 0, rd);
        frame(8'h02, a, 0, 1, 1);
        test_done;
    end
endmodule // spi_mram_array_command_decoder_tb_top
`default_nettype wire
